// ---- hdl/gpio_pkg.sv ----
// Purpose: Shared constants and carriers for the general purpose pin port.
// Assumes: 8 pins per port, byte-wide registers on 32-bit Avalon words.
// Notes: Byte address of register index k is 4*k.
package gpio_pkg;
  localparam int NPINS = 8;
  // Register indices (word offset within the port)
  localparam logic [4:0] IDX_DIR = 5'h00;
  localparam logic [4:0] IDX_DRV_SET = 5'h01;
  localparam logic [4:0] IDX_DRV_CLR = 5'h02;
  localparam logic [4:0] IDX_DRV_TGL = 5'h03;
  localparam logic [4:0] IDX_OUT = 5'h04;
  localparam logic [4:0] IDX_LVL_SET = 5'h05;
  localparam logic [4:0] IDX_LVL_CLR = 5'h06;
  localparam logic [4:0] IDX_LVL_TGL = 5'h07;
  localparam logic [4:0] IDX_IN = 5'h08;
  localparam logic [4:0] IDX_FLAGS = 5'h09;
  localparam logic [4:0] IDX_CFG0 = 5'h10;
  // Fast alias bank indices
  localparam logic [4:0] IDX_ALIAS_DIR = 5'h18;
  localparam logic [4:0] IDX_ALIAS_OUT = 5'h19;
  localparam logic [4:0] IDX_ALIAS_IN = 5'h1A;
  localparam logic [4:0] IDX_ALIAS_FLAGS = 5'h1B;
  // Config byte fields
  localparam int CFG_INV_BIT = 7;
  localparam int CFG_PULL_BIT = 3;
  localparam int CFG_SENSE_LSB = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Sense encodings
  localparam logic [2:0] SENSE_CHANGE_ONLY = 3'h0;
  localparam logic [2:0] SENSE_BOTH = 3'h1;
  localparam logic [2:0] SENSE_RISE = 3'h2;
  localparam logic [2:0] SENSE_FALL = 3'h3;
  localparam logic [2:0] SENSE_BUFFER_OFF = 3'h4;
  localparam logic [2:0] SENSE_LOW = 3'h5;
  localparam int DEAD_CYCLES = 3;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  typedef struct packed {
    logic [NPINS-1:0] o;
    logic [NPINS-1:0] oe;
    logic [NPINS-1:0] pull;
  } pin_drive_s;

  typedef struct packed {
    logic [NPINS-1:0] en;
    logic [NPINS-1:0] oe;
    logic [NPINS-1:0] o;
  } override_s;
endpackage

// ---- hdl/gpio_sense.sv ----
// Purpose: Per-pin sense detector with dead time after each flagged event.
// Assumes: Input is already synchronised to CLK and buffer-gated.
// Notes: Async wake path is combinational from the raw pin.
`timescale 1ns/10ps
`default_nettype none
module gpio_sense (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [2:0] sense,
  input wire logic lvl,
  input wire logic pin_async,
  input wire logic buf_on,
  output logic hit,
  output logic wake
);
  import gpio_pkg::*;
  logic prev_q;
  logic [1:0] dead_q;
  logic cond;

  always_comb begin
    cond = 1'b0;
    unique case (sense)
      SENSE_BOTH: cond = lvl ^ prev_q;
      SENSE_RISE: cond = lvl & ~prev_q;
      SENSE_FALL: cond = ~lvl & prev_q;
      SENSE_LOW: cond = ~lvl;
      default: cond = 1'b0;
    endcase
  end

  assign hit = cond && (dead_q == 2'd0);

  // Wake request needs no clock; level sense and both edges wake from stop
  assign wake = buf_on && ((sense == SENSE_LOW && !pin_async) ||
                (sense == SENSE_BOTH && (pin_async ^ prev_q)));

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= lvl;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dead_q <= 2'd0;
    end else if (hit) begin
      dead_q <= 2'(DEAD_CYCLES);
    end else if (dead_q != 2'd0) begin
      dead_q <= dead_q - 2'd1;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/gpio_pin_port.sv ----
// Purpose: Eight-pin general purpose port with atomic strobes and sensing.
// Assumes: Avalon-MM slave, byte data in bits 7:0, word addresses.
// Notes: Pin drive and pull outputs are registered.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - After reset drivers are off and input buffers stay on.
// - One port handles eight pins, bit n maps to pin n.
// - Enable bit turns on driver; level bit sets driven value.
// - Pin levels are synchronised and readable in either direction.
// - Set and clear strobes change only written-one enable bits.
// - Toggle strobe inverts written-one enable bits.
// - Level set strobe sets written-one level bits.
// - Level clear strobe clears written-one level bits.
// - Level toggle or writing sampled value inverts level bits.
// - Buffer-off setting freezes sampled value and disables input.
// - Pin n config byte sits at offset 0x10 plus n.
// - Polarity invert flips both sampled and driven levels.
// - Changing polarity invert creates a real internal edge.
// - Pull-up connects when enabled, never while driving.
// - Sense selects both, rising, falling or low level.
// - Pin-change wake request is registered, so WAKE needs the peripheral clock.
// - Alias bank mirrors enable, level, sampled and flag registers.
// - Peripheral override takes pins; others stay plain I/O.
// - Sense event sets flag; request holds until flag cleared.
// - Three-cycle dead time after each pin event.
// - Event output is pin value, or zero with buffer off.
module gpio_pin_port (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [gpio_pkg::NPINS-1:0] PIN_IN,
  input wire gpio_pkg::override_s PERIPH_OVR,
  output gpio_pkg::pin_drive_s PIN_DRV,
  output logic [gpio_pkg::NPINS-1:0] PIN_BUF_EN,
  output logic [gpio_pkg::NPINS-1:0] PIN_EVENT,
  output logic [gpio_pkg::NPINS-1:0] PIN_LEVEL,
  output logic IRQ,
  output logic WAKE
);
  import gpio_pkg::*;

  logic [NPINS-1:0] dir_q;
  logic [NPINS-1:0] out_q;
  logic [NPINS-1:0] in_q;
  logic [NPINS-1:0] flags_q;
  logic [7:0] cfg_q [NPINS];
  logic [NPINS-1:0] s1_q, s2_q, s3_q, stab_q;
  logic [NPINS-1:0] inv, buf_on, sense_on, hit, wake_n, lvl, phys_in;
  logic ack_q;
  logic wr, rd;
  logic [7:0] wdata;

  function automatic logic [2:0] sense_of(input logic [7:0] c);
    sense_of = c[CFG_SENSE_LSB +: 3];
  endfunction

  // One-wait-state slave: waitrequest and read data appear on the cycle after the request
  // Writes land at the edge where the master sees waitrequest low
  assign wr = AVS_WRITE && ack_q && AVS_BYTEENABLE[0];
  assign rd = AVS_READ && !ack_q;
  assign wdata = AVS_WRITEDATA[7:0];

  always_comb begin
    for (int n = 0; n < NPINS; n++) begin
      inv[n] = cfg_q[n][CFG_INV_BIT];
      buf_on[n] = sense_of(cfg_q[n]) != SENSE_BUFFER_OFF;
      sense_on[n] = buf_on[n] && !PERIPH_OVR.en[n];
      phys_in[n] = PIN_IN[n];
      lvl[n] = stab_q[n] ^ inv[n];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ || AVS_WRITE) && !ack_q;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_q);
    end
  end

  // Three-stage synchroniser; change accepted when stages two and three agree
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= phys_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stab_q <= '0;
    end else begin
      for (int n = 0; n < NPINS; n++) begin
        if (buf_on[n] && s2_q[n] == s3_q[n]) begin
          stab_q[n] <= s3_q[n];
        end
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      in_q <= REG_RESET;
    end else begin
      for (int n = 0; n < NPINS; n++) begin
        if (buf_on[n]) begin
          in_q[n] <= lvl[n];
        end
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dir_q <= REG_RESET;
    end else if (wr) begin
      unique case (AVS_ADDRESS)
        IDX_DIR, IDX_ALIAS_DIR: dir_q <= wdata;
        IDX_DRV_SET: dir_q <= dir_q | wdata;
        IDX_DRV_CLR: dir_q <= dir_q & ~wdata;
        IDX_DRV_TGL: dir_q <= dir_q ^ wdata;
        default: dir_q <= dir_q;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      out_q <= REG_RESET;
    end else if (wr) begin
      unique case (AVS_ADDRESS)
        IDX_OUT, IDX_ALIAS_OUT: out_q <= wdata;
        IDX_LVL_SET: out_q <= out_q | wdata;
        IDX_LVL_CLR: out_q <= out_q & ~wdata;
        IDX_LVL_TGL, IDX_IN, IDX_ALIAS_IN: out_q <= out_q ^ wdata;
        default: out_q <= out_q;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int n = 0; n < NPINS; n++) begin
        cfg_q[n] <= CFG_RESET;
      end
    end else if (wr && AVS_ADDRESS[4:3] == IDX_CFG0[4:3]) begin
      cfg_q[AVS_ADDRESS[2:0]] <= wdata;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flags_q <= REG_RESET;
    end else begin
      if (wr && (AVS_ADDRESS == IDX_FLAGS || AVS_ADDRESS == IDX_ALIAS_FLAGS)) begin
        flags_q <= (flags_q & ~wdata) | hit;
      end else begin
        flags_q <= flags_q | hit;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(flags_q | hit);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AVS_READDATA <= READ_UNMAPPED;
    end else if (rd) begin
      AVS_READDATA <= READ_UNMAPPED;
      unique case (AVS_ADDRESS)
        IDX_DIR, IDX_ALIAS_DIR: AVS_READDATA[7:0] <= dir_q;
        IDX_OUT, IDX_ALIAS_OUT: AVS_READDATA[7:0] <= out_q;
        IDX_IN, IDX_ALIAS_IN: AVS_READDATA[7:0] <= in_q;
        IDX_FLAGS, IDX_ALIAS_FLAGS: AVS_READDATA[7:0] <= flags_q;
        default: begin
          if (AVS_ADDRESS[4:3] == IDX_CFG0[4:3]) begin
            AVS_READDATA[7:0] <= cfg_q[AVS_ADDRESS[2:0]];
          end
        end
      endcase
    end
  end

  // Pin drive with peripheral override per pin
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PIN_DRV <= '0;
    end else begin
      for (int n = 0; n < NPINS; n++) begin
        if (PERIPH_OVR.en[n]) begin
          PIN_DRV.oe[n] <= PERIPH_OVR.oe[n];
          PIN_DRV.o[n] <= PERIPH_OVR.o[n] ^ inv[n];
          PIN_DRV.pull[n] <= cfg_q[n][CFG_PULL_BIT] && !PERIPH_OVR.oe[n];
        end else begin
          PIN_DRV.oe[n] <= dir_q[n];
          PIN_DRV.o[n] <= out_q[n] ^ inv[n];
          PIN_DRV.pull[n] <= cfg_q[n][CFG_PULL_BIT] && !dir_q[n];
        end
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PIN_BUF_EN <= '1;
    end else begin
      PIN_BUF_EN <= buf_on;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PIN_EVENT <= '0;
      PIN_LEVEL <= '0;
      WAKE <= 1'b0;
    end else begin
      PIN_EVENT <= lvl & buf_on;
      PIN_LEVEL <= lvl;
      WAKE <= |wake_n;
    end
  end

  // Per-pin sensing; the pin index is also the flag bit
  for (genvar g = 0; g < NPINS; g++) begin : g_sense
    gpio_sense u_sense (
      .CLK(CLK),
      .RST(RST),
      .sense(sense_on[g] ? sense_of(cfg_q[g]) : SENSE_CHANGE_ONLY),
      .lvl(lvl[g]),
      .pin_async(PIN_IN[g] ^ inv[g]),
      .buf_on(sense_on[g]),
      .hit(hit[g]),
      .wake(wake_n[g])
    );
  end
endmodule
`default_nettype wire

// ---- test/pin_world.sv ----
// Purpose: Outside world of the pins.
// Assumes: Bench drives every undriven pin.
// Notes: Port driver wins over the bench level.
`timescale 1ns/10ps
`default_nettype none
module pin_world (
  input wire gpio_pkg::pin_drive_s drv,
  input wire logic [7:0] ext,
  output logic [7:0] pin
);
  import gpio_pkg::*;
  assign pin = (drv.oe & drv.o) | (~drv.oe & ext);
endmodule
`default_nettype wire

// ---- test/gpio_pin_port_sva.sv ----
// Purpose: Port checker.
// Assumes: One clock.
// Notes: Bound to the top module.
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_port_sva (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire gpio_pkg::override_s PERIPH_OVR,
  input wire gpio_pkg::pin_drive_s PIN_DRV,
  input wire logic [7:0] PIN_BUF_EN,
  input wire logic [7:0] PIN_EVENT,
  input wire logic [7:0] PIN_LEVEL,
  input wire logic IRQ
);
  import gpio_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  rst_safe_a: assert property (disable iff (1'b0) RST [*2] |-> PIN_DRV.oe == 8'h00 && PIN_BUF_EN == 8'hFF)
    else $error("driver on in reset");
  pull_clash_a: assert property ((PIN_DRV.pull & PIN_DRV.oe) == 8'h00)
    else $error("pull with driver");
  wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("wait low too long");
  irq_hold_a: assert property ($fell(IRQ) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2))
    else $error("irq dropped alone");
  event_gate_a: assert property (PIN_EVENT == (PIN_LEVEL & PIN_BUF_EN))
    else $error("event with buffer off");
  empty_read_a: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS inside {[5'h0A:5'h0F], [5'h1C:5'h1F]}
    |-> AVS_READDATA == 32'h0) else $error("unmapped read data");
  ovr_drive_a: assert property (((PIN_DRV.oe ^ $past(PERIPH_OVR.oe)) & $past(PERIPH_OVR.en)) == 8'h00)
    else $error("override enable lost");
  dir_cause_a: assert property ($changed(PIN_DRV.oe) && $past(PERIPH_OVR.en) == 8'h00 &&
    $past(PERIPH_OVR.en, 2) == 8'h00 |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2) || $past(AVS_WRITE, 3))
    else $error("driver change without write");
  cover property ($rose(IRQ));
  cover property (AVS_WRITE && !AVS_WAITREQUEST);
  cover property (|(PERIPH_OVR.en & PIN_DRV.oe));
endmodule
bind gpio_pin_port gpio_pin_port_sva i_gpio_pin_port_sva (.CLK, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_READDATA, .AVS_WAITREQUEST, .PERIPH_OVR, .PIN_DRV, .PIN_BUF_EN, .PIN_EVENT, .PIN_LEVEL, .IRQ);
`default_nettype wire

// ---- test/tb.sv ----
// Purpose: Register level bench of the pin port.
// Assumes: Slave answers after one wait cycle.
// Notes: Pins come from pin_world.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import gpio_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [4:0] AVS_ADDRESS = 5'h00;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST, IRQ, WAKE;
  logic [7:0] PIN_IN, PIN_BUF_EN, PIN_EVENT, PIN_LEVEL, q;
  logic [7:0] ext = 8'h00;
  override_s PERIPH_OVR = '0;
  pin_drive_s PIN_DRV;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] tw [8] = '{32'h015A005A, 32'h020A0050, 32'h03FF00AF, 32'h053C043C,
    32'h06140428, 32'h078104A9, 32'h080119A8, 32'h18F000F0};
  logic [2:0] md [4] = '{SENSE_BOTH, SENSE_RISE, SENSE_FALL, SENSE_LOW};
  logic [1:0] ex [4] = '{2'b11, 2'b10, 2'b01, 2'b11};
  always #5 CLK = ~CLK;
  gpio_pin_port i_gpio_pin_port (.CLK, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_BYTEENABLE(4'hF),
    .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .PIN_IN, .PERIPH_OVR, .PIN_DRV, .PIN_BUF_EN,
    .PIN_EVENT, .PIN_LEVEL, .IRQ, .WAKE);
  pin_world i_pin_world (.drv(PIN_DRV), .ext, .pin(PIN_IN));
  task final_report;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    int i;
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= {24'h0, d};
    for (i = 0; i < 20; i++) begin
      @(posedge CLK);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    if (i == 20) begin
      $display("[ERR] %0t bus timeout", $time);
      n_errors++;
      final_report;
    end
    q = AVS_READDATA[7:0];
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLK);
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task wt(input int n);
    repeat (n) @(posedge CLK);
  endtask
  initial begin
    wt(6);
    RST <= 1'b0;
    wt(1);
    chk(PIN_DRV.oe, 8'h00);
    chk(PIN_BUF_EN, 8'hFF);
    rd(IDX_DIR, 8'h00);
    rd(IDX_OUT, 8'h00);
    rd(IDX_CFG0, 8'h00);
    $display("reset done");
    for (int k = 0; k < 8; k++) begin
      wr(tw[k][28:24], tw[k][23:16]);
      rd(tw[k][12:8], tw[k][7:0]);
    end
    wt(3);
    chk(PIN_DRV.oe, 8'hF0);
    chk(PIN_DRV.o, 8'hA8);
    ext <= 8'h05;
    wt(12);
    rd(IDX_IN, 8'hA5);
    rd(IDX_ALIAS_IN, 8'hA5);
    $display("strobes done");
    wr(IDX_CFG0, 8'h01);
    wr(IDX_FLAGS, 8'hFF);
    wr(IDX_CFG0, 8'h81);
    wr(5'h14, 8'h80);
    wt(12);
    rd(IDX_FLAGS, 8'h01);
    rd(IDX_IN, 8'hA4);
    chk(PIN_DRV.o, 8'hB9);
    for (int k = 0; k < 4; k++) begin
      wr(5'h11, {5'h00, md[k]});
      wr(IDX_FLAGS, 8'hFF);
      ext <= 8'h07;
      wt(12);
      rd(IDX_FLAGS, {6'h00, ex[k][1], 1'b0});
      chk({7'h00, IRQ}, {7'h00, ex[k][1]});
      wr(IDX_FLAGS, 8'hFF);
      ext <= 8'h05;
      wt(12);
      rd(IDX_FLAGS, {6'h00, ex[k][0], 1'b0});
    end
    chk({7'h00, WAKE}, 8'h01);
    wr(5'h11, 8'h00);
    wr(IDX_ALIAS_FLAGS, 8'hFF);
    wt(3);
    chk({7'h00, IRQ}, 8'h00);
    chk({7'h00, WAKE}, 8'h00);
    $display("sense done");
    wr(5'h12, {5'h00, SENSE_BUFFER_OFF});
    ext <= 8'h01;
    wt(12);
    chk(PIN_BUF_EN, 8'hFB);
    chk(PIN_EVENT, 8'hA0);
    chk(PIN_LEVEL, 8'hA4);
    rd(IDX_IN, 8'hA4);
    wr(5'h13, 8'h08);
    wt(3);
    chk(PIN_DRV.pull, 8'h08);
    wr(IDX_DRV_SET, 8'h08);
    wt(3);
    chk(PIN_DRV.pull, 8'h00);
    $display("config done");
    PERIPH_OVR <= '{8'h02, 8'h02, 8'h00};
    wt(3);
    chk(PIN_DRV.oe, 8'hFA);
    wr(IDX_DRV_TGL, 8'h80);
    wt(3);
    chk(PIN_DRV.oe, 8'h7A);
    PERIPH_OVR <= '0;
    wr(5'h0C, 8'hFF);
    rd(5'h0C, 8'h00);
    rd(IDX_DIR, 8'h78);
    $display("override done");
    final_report;
  end
endmodule
`default_nettype wire
